// file: logic/dram_vref_invert_partial_array_self_refresh_mode_regs.sv
`timescale 1ns/1ps
`default_nettype none
module dram_vref_invert_partial_array_self_refresh_mode_regs #(
  parameter int DENSITY_GB = mode_regs_pkg::DENSITY_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Command link pins
  input  wire logic        ck_in,
  input  wire logic        mrw_in,
  input  wire logic        mrr_in,
  input  wire logic        rdcal_in,
  input  wire logic [5:0]  ma_in,
  input  wire logic [7:0]  op_in,
  // Calibration pattern source
  input  wire logic [7:0]  cal_pattern_in,
  input  wire logic        cal_mask_bit_in,
  // Refresh engine query
  input  wire logic [2:0]  refresh_bank_in,
  input  wire logic [16:0] refresh_row_in,
  // Lower data lines
  output logic [7:0]       dq_out,
  output logic             dq_oe_out,
  output logic             mask_line_out,
  output logic             mask_line_oe_out,
  // Active reference
  output logic [5:0]       vref_code_out,
  output logic             vref_range_out,
  output logic [9:0]       vref_tenths_out,
  output logic             vref_reserved_out,
  // Set-point selectors
  output logic             setpoint_write_out,
  output logic             setpoint_operate_out,
  // Masks
  output logic [7:0]       invert_mask_out,
  output logic [7:0]       bank_mask_out,
  output logic [7:0]       segment_mask_out,
  output logic             refresh_skip_out
);

  localparam int CMD_W = 17;

  // ==========================================================
  // State
  typedef struct packed {
    logic                   sp_write;
    logic                   sp_operate;
    logic [1:0][5:0]        code;
    logic [1:0]             range;
    logic [7:0]             invert;
    logic [7:0]             bank;
    logic [7:0]             segment;
    mode_regs_pkg::answer_e answer;
    logic [7:0]             dq;
    logic                   dq_oe;
    logic                   mask_line;
    logic                   mask_line_oe;
    logic [5:0]             act_code;
    logic                   act_range;
    logic [9:0]             act_tenths;
    logic                   act_reserved;
  } regs_s;

  regs_s              state_reg;
  regs_s              state_next;
  logic               link_edge;
  logic [CMD_W-1:0]   link_cmd;
  logic               cmd_write;
  logic               cmd_read;
  logic               cmd_cal;
  logic [5:0]         cmd_addr;
  logic [7:0]         cmd_op;
  logic               wr_sel;
  logic               op_sel;
  logic [7:0]         read_word;
  logic [1:0][9:0]    copy_level;
  logic [1:0]         copy_reserved;

  // ==========================================================
  // Link sampling
  link_sampler #(
    .W (CMD_W)
  ) u_link (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ck_in    (ck_in),
    .cmd_in   ({mrw_in, mrr_in, rdcal_in, ma_in, op_in}),
    .edge_out (link_edge),
    .cmd_out  (link_cmd)
  );

  assign cmd_write = link_edge & link_cmd[16];
  // A write wins over a read or calibration read on the same edge
  assign cmd_read  = link_edge & ~link_cmd[16] & link_cmd[15];
  assign cmd_cal   = link_edge & ~link_cmd[16] & ~link_cmd[15] &
                     link_cmd[14];
  assign cmd_addr  = link_cmd[13:8];
  assign cmd_op    = link_cmd[7:0];

  assign wr_sel = state_reg.sp_write;
  assign op_sel = state_reg.sp_operate;

  // ==========================================================
  // Read data
  always_comb begin
    read_word = 8'h00;
    if (cmd_addr == mode_regs_pkg::ADDR_DQ_REF) begin
      read_word = {1'b0, state_reg.range[wr_sel],
                   state_reg.code[wr_sel]};
    end
  end

  // ==========================================================
  // Reference level of each set-point copy
  // Both copies are decoded so a set-point switch costs no
  // extra cycle; the inactive result is simply not selected
  for (genvar sp = 0; sp < 2; sp++) begin : g_copy
    assign copy_level[sp] =
      10'((state_reg.range[sp] ? mode_regs_pkg::BASE_RANGE1 :
                                 mode_regs_pkg::BASE_RANGE0) +
          mode_regs_pkg::LEVEL_STEP *
          10'(state_reg.code[sp]));
    // Reserved codes are kept, only flagged
    assign copy_reserved[sp] =
      state_reg.code[sp] > mode_regs_pkg::CODE_MAX;
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;

    // Register writes
    if (cmd_write) begin
      unique case (cmd_addr)
        mode_regs_pkg::ADDR_SETPOINT_CTRL: begin
          state_next.sp_write =
            cmd_op[mode_regs_pkg::SP_WRITE_BIT];
          state_next.sp_operate =
            cmd_op[mode_regs_pkg::SP_OPERATE_BIT];
        end
        mode_regs_pkg::ADDR_DQ_REF: begin
          // Reserved codes are stored as written; flagged below
          state_next.code[wr_sel] =
            cmd_op[mode_regs_pkg::CODE_MSB:0];
          state_next.range[wr_sel] =
            cmd_op[mode_regs_pkg::RANGE_BIT];
        end
        mode_regs_pkg::ADDR_LOWER_INVERT: begin
          state_next.invert = cmd_op;
        end
        mode_regs_pkg::ADDR_BANK_MASK: begin
          state_next.bank = cmd_op;
        end
        mode_regs_pkg::ADDR_SEGMENT_MASK: begin
          state_next.segment = cmd_op;
        end
        default: begin
          // Other addresses belong to other blocks; held values stay
          state_next.sp_write = state_reg.sp_write;
        end
      endcase
    end

    // Answer drive: one link period, ended by the next link edge
    unique case (state_reg.answer)
      mode_regs_pkg::ANSWER_IDLE: begin
        if (cmd_read) begin
          state_next.answer       = mode_regs_pkg::ANSWER_DRIVE;
          state_next.dq           = read_word;
          state_next.dq_oe        = 1'b1;
          state_next.mask_line    = 1'b0;
          state_next.mask_line_oe = 1'b1;
        end else if (cmd_cal) begin
          state_next.answer       = mode_regs_pkg::ANSWER_DRIVE;
          // Pattern goes out raw apart from the invert mask
          state_next.dq           = cal_pattern_in ^
                                    state_reg.invert;
          state_next.dq_oe        = 1'b1;
          state_next.mask_line    = cal_mask_bit_in;
          state_next.mask_line_oe = 1'b1;
        end
      end
      mode_regs_pkg::ANSWER_DRIVE: begin
        if (link_edge) begin
          state_next.answer       = mode_regs_pkg::ANSWER_IDLE;
          state_next.dq           = 8'h00;
          state_next.dq_oe        = 1'b0;
          state_next.mask_line    = 1'b0;
          state_next.mask_line_oe = 1'b0;
        end
      end
    endcase

    // Active reference outputs track the operating copy
    state_next.act_code     = state_reg.code[op_sel];
    state_next.act_range    = state_reg.range[op_sel];
    state_next.act_tenths   = copy_level[op_sel];
    state_next.act_reserved = copy_reserved[op_sel];
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg.sp_write     <= mode_regs_pkg::SP_RESET;
      state_reg.sp_operate   <= mode_regs_pkg::SP_RESET;
      state_reg.code[0]      <= mode_regs_pkg::CODE_RESET;
      state_reg.code[1]      <= mode_regs_pkg::CODE_RESET;
      state_reg.range[0]     <= mode_regs_pkg::RANGE_RESET;
      state_reg.range[1]     <= mode_regs_pkg::RANGE_RESET;
      state_reg.invert       <= mode_regs_pkg::INVERT_RESET;
      state_reg.bank         <= mode_regs_pkg::BANK_RESET;
      state_reg.segment      <= mode_regs_pkg::SEGMENT_RESET;
      state_reg.answer       <= mode_regs_pkg::ANSWER_IDLE;
      state_reg.dq           <= 8'h00;
      state_reg.dq_oe        <= 1'b0;
      state_reg.mask_line    <= 1'b0;
      state_reg.mask_line_oe <= 1'b0;
      state_reg.act_code     <= mode_regs_pkg::CODE_RESET;
      state_reg.act_range    <= mode_regs_pkg::RANGE_RESET;
      state_reg.act_tenths   <= 10'h110;
      state_reg.act_reserved <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Refresh verdict
  refresh_gate #(
    .DENSITY_GB (DENSITY_GB)
  ) u_gate (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .bank_mask_in    (state_reg.bank),
    .segment_mask_in (state_reg.segment),
    .bank_in         (refresh_bank_in),
    .row_in          (refresh_row_in),
    .skip_out        (refresh_skip_out)
  );

  // ==========================================================
  // Outputs
  assign dq_out               = state_reg.dq;
  assign dq_oe_out            = state_reg.dq_oe;
  assign mask_line_out        = state_reg.mask_line;
  assign mask_line_oe_out     = state_reg.mask_line_oe;
  assign vref_code_out        = state_reg.act_code;
  assign vref_range_out       = state_reg.act_range;
  assign vref_tenths_out      = state_reg.act_tenths;
  assign vref_reserved_out    = state_reg.act_reserved;
  assign setpoint_write_out   = state_reg.sp_write;
  assign setpoint_operate_out = state_reg.sp_operate;
  assign invert_mask_out      = state_reg.invert;
  assign bank_mask_out        = state_reg.bank;
  assign segment_mask_out     = state_reg.segment;

endmodule : dram_vref_invert_partial_array_self_refresh_mode_regs
`default_nettype wire

// file: logic/link_sampler.sv
`timescale 1ns/1ps
`default_nettype none
module link_sampler #(
  parameter int W = 17
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Link pins
  input  wire logic         ck_in,
  input  wire logic [W-1:0] cmd_in,
  // Sampled command
  output logic              edge_out,
  output logic [W-1:0]      cmd_out
);

  typedef struct packed {
    logic         ck_meta;
    logic         ck_sync;
    logic         ck_prev;
    logic [W-1:0] cmd_meta;
    logic [W-1:0] cmd_sync;
    logic         edge_seen;
    logic [W-1:0] cmd;
  } sampler_s;

  sampler_s state_reg;
  sampler_s state_next;

  // ==========================================================
  // Sampling
  // Command pins share the clock pins' latency, so the pair
  // stays aligned as long as commands are held around the edge
  always_comb begin
    state_next           = state_reg;
    state_next.ck_meta   = ck_in;
    state_next.ck_sync   = state_reg.ck_meta;
    state_next.ck_prev   = state_reg.ck_sync;
    state_next.cmd_meta  = cmd_in;
    state_next.cmd_sync  = state_reg.cmd_meta;
    state_next.edge_seen = state_reg.ck_sync & ~state_reg.ck_prev;
    if (state_reg.ck_sync & ~state_reg.ck_prev) begin
      state_next.cmd = state_reg.cmd_sync;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign edge_out = state_reg.edge_seen;
  assign cmd_out  = state_reg.cmd;

endmodule : link_sampler
`default_nettype wire

// file: logic/mode_regs_pkg.sv
`default_nettype none
package mode_regs_pkg;

  // ==========================================================
  // Mode register addresses
  localparam logic [5:0] ADDR_SETPOINT_CTRL = 6'h0d;
  localparam logic [5:0] ADDR_DQ_REF        = 6'h0e;
  localparam logic [5:0] ADDR_LOWER_INVERT  = 6'h0f;
  localparam logic [5:0] ADDR_BANK_MASK     = 6'h10;
  localparam logic [5:0] ADDR_SEGMENT_MASK  = 6'h11;

  // ==========================================================
  // Field positions
  localparam int SP_WRITE_BIT   = 6;
  localparam int SP_OPERATE_BIT = 7;
  localparam int RANGE_BIT      = 6;
  localparam int CODE_MSB       = 5;

  // ==========================================================
  // Reset values
  localparam logic [5:0] CODE_RESET     = 6'h0d;
  localparam logic       RANGE_RESET    = 1'b1;
  localparam logic       SP_RESET       = 1'b0;
  localparam logic [7:0] INVERT_RESET   = 8'h55;
  localparam logic [7:0] BANK_RESET     = 8'h00;
  localparam logic [7:0] SEGMENT_RESET  = 8'h00;

  // ==========================================================
  // Reference level mapping, in tenths of a percent
  localparam logic [5:0] CODE_MAX    = 6'h32;
  localparam logic [9:0] BASE_RANGE0 = 10'h064;
  localparam logic [9:0] BASE_RANGE1 = 10'h0dc;
  localparam logic [9:0] LEVEL_STEP  = 10'h004;

  // ==========================================================
  // Link sampling
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // Segment decode per density in Gb per channel
  localparam int DENSITY_DEFAULT = 16;

  function automatic int segment_low_bit(input int density_gb);
    int low;
    low = 14;
    if (density_gb <= 1) begin
      low = 10;
    end else if (density_gb <= 2) begin
      low = 11;
    end else if (density_gb <= 4) begin
      low = 12;
    end else if (density_gb <= 8) begin
      low = 13;
    end
    return low;
  endfunction : segment_low_bit

  function automatic bit odd_density(input int density_gb);
    return (density_gb == 3) || (density_gb == 6) || (density_gb == 12);
  endfunction : odd_density

  // ==========================================================
  // Read answer state
  typedef enum logic [0:0] {
    ANSWER_IDLE  = 1'b0,
    ANSWER_DRIVE = 1'b1
  } answer_e;

endpackage : mode_regs_pkg
`default_nettype wire

// file: logic/refresh_gate.sv
`timescale 1ns/1ps
`default_nettype none
module refresh_gate #(
  parameter int DENSITY_GB = mode_regs_pkg::DENSITY_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Masks
  input  wire logic [7:0]  bank_mask_in,
  input  wire logic [7:0]  segment_mask_in,
  // Refresh target
  input  wire logic [2:0]  bank_in,
  input  wire logic [16:0] row_in,
  // Verdict
  output logic             skip_out
);

  localparam int LOW = mode_regs_pkg::segment_low_bit(DENSITY_GB);

  typedef struct packed {
    logic skip;
  } gate_s;

  gate_s      state_reg;
  gate_s      state_next;
  logic [2:0] segment;
  logic [7:0] seg_usable;

  // ==========================================================
  // Segment decode
  assign segment = row_in[LOW+2 -: 3];

  // Top two segments do not exist at odd densities
  assign seg_usable = mode_regs_pkg::odd_density(DENSITY_GB) ?
                      {2'h0, segment_mask_in[5:0]} : segment_mask_in;

  always_comb begin
    state_next      = state_reg;
    state_next.skip = bank_mask_in[bank_in] | seg_usable[segment];
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign skip_out = state_reg.skip;

endmodule : refresh_gate
`default_nettype wire

// file: tb/controller_model.sv
`timescale 1ns/1ps
`default_nettype none
module controller_model #(
  parameter int DENSITY_GB = 16
) (
  // Clock
  input  wire logic  clk_in,
  // Command link
  output logic       ck_out,
  output logic       mrw_out,
  output logic       mrr_out,
  output logic       rdcal_out,
  output logic [5:0] ma_out,
  output logic [7:0] op_out
);
  // ========
  // Link clock parked low outside frames
  initial begin
    ck_out = 1'b0;
    {mrw_out, mrr_out, rdcal_out} = 3'b000;
    ma_out = 6'h00;
    op_out = 8'h00;
  end

  // ========
  // One frame: setup, single rise, hold, release
  task automatic send(input logic [2:0] kind, input logic [5:0] ma,
                      input logic [7:0] op);
    logic [7:0] d;
    d = op;
    if (ma == 6'h11 && (DENSITY_GB % 3 == 0)) begin
      d[7:6] = 2'b00;
    end
    @(negedge clk_in);
    {mrw_out, mrr_out, rdcal_out} = kind;
    ma_out = ma;
    op_out = d;
    repeat (4) @(negedge clk_in);
    ck_out = 1'b1;
    repeat (4) @(negedge clk_in);
    ck_out = 1'b0;
    // Varied low time: prompt and slow frames
    repeat (4 + ($urandom % 4)) @(negedge clk_in);
    {mrw_out, mrr_out, rdcal_out} = 3'b000;
    // Released lines flip so a stale value cannot pass
    ma_out = ~ma_out;
    op_out = ~op_out;
  endtask : send
endmodule : controller_model
`default_nettype wire

// file: tb/mode_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mode_regs_checker #(
  parameter int DENSITY_GB = 16
) (
  // Clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // Inputs watched
  input wire logic        ck_in,
  input wire logic [2:0]  refresh_bank_in,
  input wire logic [16:0] refresh_row_in,
  // Outputs watched
  input wire logic [7:0]  dq_out,
  input wire logic        dq_oe_out,
  input wire logic        mask_line_oe_out,
  input wire logic [5:0]  vref_code_out,
  input wire logic        vref_range_out,
  input wire logic [9:0]  vref_tenths_out,
  input wire logic        vref_reserved_out,
  input wire logic        setpoint_write_out,
  input wire logic [7:0]  invert_mask_out,
  input wire logic [7:0]  bank_mask_out,
  input wire logic [7:0]  segment_mask_out,
  input wire logic        refresh_skip_out
);
  // ========
  // Segment decode, top two bits unused at odd densities
  localparam int SEG_LO = (DENSITY_GB > 8) ? 14 : (DENSITY_GB > 4) ? 13 :
                          (DENSITY_GB > 2) ? 12 : (DENSITY_GB > 1) ? 11 : 10;
  localparam logic [7:0] SEG_USE = (DENSITY_GB == 3 || DENSITY_GB == 6 ||
                                    DENSITY_GB == 12) ? 8'h3f : 8'hff;
  logic [7:0] seg_eff;
  assign seg_eff = segment_mask_out & SEG_USE;

  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // ========
  // Checks
  a_reset_defaults: assert property (
    $fell(rst_in) |-> invert_mask_out == 8'h55 && vref_tenths_out == 10'h110
      && bank_mask_out == 8'h00 && segment_mask_out == 8'h00 && !dq_oe_out)
    else $error("defaults missing after reset");
  a_tenths_linear: assert property (
    vref_tenths_out == (vref_range_out ? 10'h0dc : 10'h064)
      + {2'b00, vref_code_out, 2'b00}) else $error("reference level wrong");
  a_reserved_flag: assert property (
    vref_reserved_out == (vref_code_out > 6'h32)) else $error("flag wrong");
  a_enables_paired: assert property (
    dq_oe_out == mask_line_oe_out) else $error("line enables differ");
  a_idle_lines_low: assert property (
    !dq_oe_out |-> dq_out == 8'h00) else $error("data lines not zero");
  a_drive_steady: assert property (
    $past(dq_oe_out) && dq_oe_out |-> $stable(dq_out))
    else $error("read data moved while driven");
  a_skip_lookup: assert property (
    refresh_skip_out == $past(bank_mask_out[refresh_bank_in]
      | seg_eff[refresh_row_in[SEG_LO +: 3]])) else $error("skip wrong");
  a_quiet_hold: assert property (
    !ck_in [*6] |=> $stable({invert_mask_out, bank_mask_out, segment_mask_out,
      vref_code_out, vref_range_out, setpoint_write_out}))
    else $error("register changed without command");
endmodule : mode_regs_checker

bind dram_vref_invert_partial_array_self_refresh_mode_regs mode_regs_checker #(
  .DENSITY_GB(DENSITY_GB)
) i_mode_regs_checker (
  .clk_in(clk_in), .rst_in(rst_in), .ck_in(ck_in),
  .refresh_bank_in(refresh_bank_in), .refresh_row_in(refresh_row_in),
  .dq_out(dq_out), .dq_oe_out(dq_oe_out),
  .mask_line_oe_out(mask_line_oe_out), .vref_code_out(vref_code_out),
  .vref_range_out(vref_range_out), .vref_tenths_out(vref_tenths_out),
  .vref_reserved_out(vref_reserved_out),
  .setpoint_write_out(setpoint_write_out),
  .invert_mask_out(invert_mask_out), .bank_mask_out(bank_mask_out),
  .segment_mask_out(segment_mask_out), .refresh_skip_out(refresh_skip_out)
);
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ========
  // Signals
  logic        clk_in, rst_in, ck_in, mrw_in, mrr_in, rdcal_in;
  logic        cal_mask_bit_in, refresh_skip_out, dq_oe_out, was_on;
  logic        mask_line_out, mask_line_oe_out, vref_range_out;
  logic        vref_reserved_out, setpoint_write_out, setpoint_operate_out;
  logic [5:0]  ma_in, vref_code_out;
  logic [7:0]  op_in, cal_pattern_in, dq_out, invert_mask_out;
  logic [7:0]  bank_mask_out, segment_mask_out;
  logic [2:0]  refresh_bank_in;
  logic [16:0] refresh_row_in;
  logic [9:0]  vref_tenths_out;
  logic [9:0]  expq[$];
  int          error_cnt, n_compared;

  controller_model #(.DENSITY_GB(16)) i_controller_model (
    .clk_in(clk_in), .ck_out(ck_in), .mrw_out(mrw_in), .mrr_out(mrr_in),
    .rdcal_out(rdcal_in), .ma_out(ma_in), .op_out(op_in));

  dram_vref_invert_partial_array_self_refresh_mode_regs #(.DENSITY_GB(16))
    i_dram_vref_invert_partial_array_self_refresh_mode_regs (
    .clk_in(clk_in), .rst_in(rst_in), .ck_in(ck_in), .mrw_in(mrw_in),
    .mrr_in(mrr_in), .rdcal_in(rdcal_in), .ma_in(ma_in), .op_in(op_in),
    .cal_pattern_in(cal_pattern_in), .cal_mask_bit_in(cal_mask_bit_in),
    .refresh_bank_in(refresh_bank_in), .refresh_row_in(refresh_row_in),
    .dq_out(dq_out), .dq_oe_out(dq_oe_out), .mask_line_out(mask_line_out),
    .mask_line_oe_out(mask_line_oe_out), .vref_code_out(vref_code_out),
    .vref_range_out(vref_range_out), .vref_tenths_out(vref_tenths_out),
    .vref_reserved_out(vref_reserved_out),
    .setpoint_write_out(setpoint_write_out),
    .setpoint_operate_out(setpoint_operate_out),
    .invert_mask_out(invert_mask_out), .bank_mask_out(bank_mask_out),
    .segment_mask_out(segment_mask_out), .refresh_skip_out(refresh_skip_out));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // ========
  // Shared tasks
  task automatic check(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("compared %0d, errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : close_out

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    i_controller_model.send(3'b100, a, d);
  endtask : wr

  // Idle frame after each read ends the drive
  task automatic rd(input logic [2:0] k, input logic [5:0] a,
                    input logic [9:0] e);
    expq.push_back(e);
    i_controller_model.send(k, a, 8'h00);
    i_controller_model.send(3'b000, a, 8'h00);
  endtask : rd

  // ========
  // Read monitor: oldest note against each new drive
  always @(negedge clk_in) begin
    if (dq_oe_out === 1'b1 && was_on !== 1'b1) begin
      if (expq.size() == 0) begin
        check(10'h3ff, 10'h000);
      end else begin
        check(10'(dq_out), 10'(expq[0][7:0]));
        if (expq[0][9]) begin
          check(10'(mask_line_out), 10'(expq[0][8]));
        end
        void'(expq.pop_front());
      end
    end
    was_on <= dq_oe_out;
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    error_cnt++;
    close_out();
  end

  // ========
  // Main sequence
  initial begin
    logic [7:0] c, inv, pat, bm, sm;
    logic       mb;
    void'($urandom(61730));
    rst_in = 1'b1;
    cal_pattern_in = 8'h00;
    cal_mask_bit_in = 1'b0;
    refresh_bank_in = 3'h0;
    refresh_row_in = 17'h00000;
    repeat (16) @(negedge clk_in);
    rst_in = 1'b0;
    check(10'({vref_range_out, vref_code_out}), 10'h04d);
    check(vref_tenths_out, 10'h110);
    check(10'(bank_mask_out | segment_mask_out), 10'h000);
    rd(3'b010, 6'h0e, 10'h04d);
    wr(6'h0e, 8'hca);
    check(vref_tenths_out, 10'h104);
    rd(3'b010, 6'h0e, 10'h04a);
    wr(6'h0d, 8'h40);
    wr(6'h0e, 8'h05);
    check(10'({setpoint_operate_out, setpoint_write_out, vref_range_out,
               vref_code_out}), 10'h0ca);
    rd(3'b010, 6'h0e, 10'h005);
    wr(6'h0d, 8'hc0);
    check(10'({setpoint_operate_out, setpoint_write_out, vref_range_out,
               vref_code_out}), 10'h185);
    check(vref_tenths_out, 10'h078);
    wr(6'h0d, 8'h80);
    rd(3'b010, 6'h0e, 10'h04a);
    wr(6'h0d, 8'h00);
    for (int i = 0; i < 4; i++) begin
      c = (i == 0) ? 8'h32 : (i == 1) ? 8'h73 : 8'($urandom);
      wr(6'h0e, c);
      check(vref_tenths_out,
            (c[6] ? 10'h0dc : 10'h064) + {2'b00, c[5:0], 2'b00});
      check(10'(vref_reserved_out), 10'(c[5:0] > 6'h32));
    end
    for (int i = 0; i < 3; i++) begin
      inv = (i == 0) ? 8'h55 : 8'($urandom);
      pat = 8'($urandom);
      mb = 1'($urandom);
      if (i > 0) begin
        wr(6'h0f, inv);
      end
      check(10'(invert_mask_out), 10'(inv));
      cal_pattern_in = pat;
      cal_mask_bit_in = mb;
      rd(3'b001, 6'h00, {1'b1, mb, pat ^ inv});
    end
    bm = 8'($urandom);
    sm = 8'($urandom);
    wr(6'h10, bm);
    wr(6'h11, sm);
    check(10'(bank_mask_out), 10'(bm));
    check(10'(segment_mask_out), 10'(sm));
    for (int i = 0; i < 16; i++) begin
      refresh_bank_in = 3'($urandom);
      refresh_row_in = 17'($urandom);
      @(negedge clk_in);
      check(10'(refresh_skip_out), 10'(bm[refresh_bank_in]
            | sm[refresh_row_in[16:14]]));
    end
    wr(6'h12, 8'hff);
    check(10'(bank_mask_out ^ segment_mask_out), 10'(bm ^ sm));
    rd(3'b010, 6'h20, 10'h000);
    rd(3'b010, 6'h0f, 10'h000);
    rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rst_in = 1'b0;
    check(10'(invert_mask_out), 10'h055);
    check(vref_tenths_out, 10'h110);
    repeat (4) @(negedge clk_in);
    check(10'(expq.size()), 10'h000);
    close_out();
  end
endmodule : testbench
`default_nettype wire
